/* File: design/cpuie_top.sv */
// Purpose: interrupt entry, return and instruction status pins
// Assumes: inputs synchronous to clk_in; bus answers with bus_done_in
// Notes: one bus request outstanding at a time
// Notes on behaviour
// - instruction start pin pulses low once per started instruction.
// - user/supervisor pin follows status word user bit, valid in bus cycles.
// - interlock pin active through set/clear-bit locked instructions.
// - status pins timed from execution events, not bus cycle states.
// - entry copies status, enters supervisor, pushes 16-bit copy.
// - dispatch via base table, 32-bit descriptor, push 16-bit module, 32-bit pc.
// - trap return restores status, module, pc, static base; drops parameters.
// - irq return issues end-of-interrupt cycle, pops no parameters.
// - maskable request is a level, repeats while low, needs enable bit.
// - entry for maskable, nonmaskable, abort clears enable; return restores.
// - config bit 0 means nonvectored, 1 means vectored.
// - nonvectored still acknowledges but uses vector zero.
// - vectored acknowledge takes vector from low data byte.
// - cascade index -16..-1 addresses base plus four times index.
// - cascaded acknowledge at cascade address, vector unsigned 0..255.
// - irq return runs master end cycle; byte -16..-1 adds cascaded end cycle.
// - abort on reset/abort pin raises an interrupt request.
// - vectored acknowledge reads lower acknowledge address with code 0100.
// - nonvectored acknowledge reads upper acknowledge address, vector zero.
// - cascaded vector read at cascade address with code 0101.
// - bytes -16..-1 are cascaded; more negative values are reserved.
`timescale 1ns/1ps
module cpuie_top (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic instr_start_in,
  input wire logic instr_boundary_in,
  input wire logic [31:0] ret_addr_in,
  input wire logic set_bit_locked_instr_in,
  input wire logic clear_bit_locked_instr_in,
  input wire logic int_n_in,
  input wire logic nmi_n_in,
  input wire logic reset_abort_n_in,
  input wire logic trap_req_in,
  input wire logic [7:0] trap_vec_in,
  input wire logic return_from_trap_instr_in,
  input wire logic [15:0] return_from_trap_instr_discard_in,
  input wire logic return_from_irq_instr_in,
  input wire logic set_config_instr_in,
  input wire logic cfg_vectored_in,
  input wire logic psr_load_in,
  input wire logic [15:0] psr_wdata_in,
  input wire logic base_load_in,
  input wire logic [31:0] base_wdata_in,
  input wire logic isp_load_in,
  input wire logic [31:0] isp_wdata_in,
  input wire logic bus_done_in,
  input wire logic [31:0] bus_rdata_in,
  output logic bus_req_out,
  output cpuie_pkg::cpuie_bus_cmd_t bus_cmd_out,
  output logic instr_start_pulse_n_out,
  output logic user_mode_out,
  output logic interlock_n_out,
  output logic busy_out,
  output logic reserved_vec_out,
  output logic [15:0] psr_out,
  output logic [15:0] module_reg_out,
  output logic [31:0] static_base_out,
  output logic [31:0] pc_out,
  output logic [31:0] isp_out,
  output logic [7:0] vector_out
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  cpuie_pkg::cpuie_state_t state_r;
  cpuie_pkg::cpuie_kind_t kind_r;
  cpuie_pkg::cpuie_bus_cmd_t cmd_r;
  cpuie_pkg::cpuie_bus_cmd_t cmd_nxt;
  logic req_r;
  logic [15:0] psr_r;
  logic [15:0] psr_copy_r;
  logic [15:0] mod_r;
  logic [15:0] offs_r;
  logic [15:0] discard_r;
  logic [31:0] sb_r;
  logic [31:0] pc_r;
  logic [31:0] isp_r;
  logic [31:0] base_r;
  logic [31:0] caddr_r;
  logic [31:0] ret_pc_r;
  logic [7:0] vec_r;
  logic [7:0] byte_r;
  logic cfg_vec_r;
  logic is_return_from_irq_instr_r;
  logic nmi_d_r;
  logic nmi_pend_r;
  logic abt_pend_r;
  logic start_pulse_n_r;
  logic user_r;
  logic lock_n_r;
  logic resv_r;
  logic busy_r;
  logic done_c;
  logic idle_c;
  logic go_ret_c;
  logic go_trap_c;
  logic go_abt_c;
  logic go_nmi_c;
  logic go_int_c;
  logic go_irq_c;
  logic [7:0] rbyte_c;
  logic rbyte_casc_c;
  logic [31:0] casc_ofs_c;

  assign done_c = req_r && bus_done_in;
  assign idle_c = (state_r == cpuie_pkg::S_IDLE);
  assign rbyte_c = bus_rdata_in[7:0];
  assign rbyte_casc_c = rbyte_c >= cpuie_pkg::CASC_MIN;
  assign casc_ofs_c = {{22{byte_r[7]}}, byte_r, 2'b00};
  assign go_ret_c = idle_c &&
    (return_from_trap_instr_in || return_from_irq_instr_in);
  assign go_trap_c = idle_c && !go_ret_c && instr_boundary_in && trap_req_in;
  assign go_abt_c = idle_c && !go_ret_c && !go_trap_c && abt_pend_r;
  assign go_nmi_c = idle_c && !go_ret_c && !go_trap_c && !abt_pend_r &&
    instr_boundary_in && nmi_pend_r;
  assign go_int_c = idle_c && !go_ret_c && !go_trap_c && !abt_pend_r &&
    !nmi_pend_r && instr_boundary_in && !int_n_in && psr_r[cpuie_pkg::PSR_I];
  assign go_irq_c = go_nmi_c || go_int_c;

  // ---------------------------------------------------------------
  // request pending flags
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      nmi_d_r <= 1'b1;
      nmi_pend_r <= 1'b0;
      abt_pend_r <= 1'b0;
    end
    else
    begin
      nmi_d_r <= nmi_n_in;
      // a new edge wins over the clear of the one taken
      if (nmi_d_r && !nmi_n_in)
        nmi_pend_r <= 1'b1;
      else if (go_nmi_c)
        nmi_pend_r <= 1'b0;
      if (!reset_abort_n_in)
        abt_pend_r <= 1'b1;
      else if (go_abt_c)
        abt_pend_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // bus command for the current state
  // ---------------------------------------------------------------
  always_comb
  begin
    cmd_nxt = '0;
    cmd_nxt.status = cpuie_pkg::STS_DATA;
    cmd_nxt.size = cpuie_pkg::SZ_WORD;
    case (state_r)
      cpuie_pkg::S_ACK:
      begin
        cmd_nxt.addr = (kind_r == cpuie_pkg::K_NMI || !cfg_vec_r) ?
          cpuie_pkg::ADDR_ACK_NOVEC : cpuie_pkg::ADDR_ACK_VEC;
        cmd_nxt.status = cpuie_pkg::STS_ACK_MASTER;
        cmd_nxt.size = cpuie_pkg::SZ_BYTE;
      end
      cpuie_pkg::S_CADDR, cpuie_pkg::S_EOICA:
        cmd_nxt.addr = base_r + casc_ofs_c;
      cpuie_pkg::S_CACK:
      begin
        cmd_nxt.addr = caddr_r;
        cmd_nxt.status = cpuie_pkg::STS_ACK_CASC;
        cmd_nxt.size = cpuie_pkg::SZ_BYTE;
      end
      cpuie_pkg::S_PSR:
      begin
        cmd_nxt.addr = isp_r - cpuie_pkg::OFS_HALF;
        cmd_nxt.write = 1'b1;
        cmd_nxt.size = cpuie_pkg::SZ_HALF;
        cmd_nxt.wdata = {16'h0000, psr_copy_r};
      end
      cpuie_pkg::S_DESC:
        cmd_nxt.addr = base_r + {22'h000000, vec_r, 2'b00};
      cpuie_pkg::S_SB, cpuie_pkg::S_RSB:
        cmd_nxt.addr = {16'h0000, mod_r};
      cpuie_pkg::S_PB:
        cmd_nxt.addr = {16'h0000, mod_r} + cpuie_pkg::OFS_PROG_BASE;
      cpuie_pkg::S_MOD:
      begin
        cmd_nxt.addr = isp_r - cpuie_pkg::OFS_HALF;
        cmd_nxt.write = 1'b1;
        cmd_nxt.size = cpuie_pkg::SZ_HALF;
        cmd_nxt.wdata = {16'h0000, mod_r};
      end
      cpuie_pkg::S_PC:
      begin
        cmd_nxt.addr = isp_r - cpuie_pkg::OFS_WORD;
        cmd_nxt.write = 1'b1;
        cmd_nxt.wdata = ret_pc_r;
      end
      cpuie_pkg::S_RPC:
        cmd_nxt.addr = isp_r;
      cpuie_pkg::S_RMOD:
      begin
        cmd_nxt.addr = isp_r + cpuie_pkg::OFS_WORD;
        cmd_nxt.size = cpuie_pkg::SZ_HALF;
      end
      cpuie_pkg::S_RPSR:
      begin
        cmd_nxt.addr = isp_r + cpuie_pkg::OFS_POP_PSR;
        cmd_nxt.size = cpuie_pkg::SZ_HALF;
      end
      cpuie_pkg::S_EOIM:
      begin
        cmd_nxt.addr = cpuie_pkg::ADDR_ACK_VEC;
        cmd_nxt.status = cpuie_pkg::STS_EOI_MASTER;
        cmd_nxt.size = cpuie_pkg::SZ_BYTE;
      end
      cpuie_pkg::S_EOIC:
      begin
        cmd_nxt.addr = caddr_r;
        cmd_nxt.status = cpuie_pkg::STS_EOI_CASC;
        cmd_nxt.size = cpuie_pkg::SZ_BYTE;
      end
      default:
        cmd_nxt = '0;
    endcase
  end

  // ---------------------------------------------------------------
  // bus handshake: launch once per state, drop on done
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      req_r <= 1'b0;
      cmd_r <= '0;
    end
    else if (done_c)
      req_r <= 1'b0;
    else if (!req_r && !idle_c)
    begin
      req_r <= 1'b1;
      cmd_r <= cmd_nxt;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_r <= cpuie_pkg::S_IDLE;
      kind_r <= cpuie_pkg::K_TRAP;
      is_return_from_irq_instr_r <= 1'b0;
      vec_r <= 8'h00;
      byte_r <= 8'h00;
      resv_r <= 1'b0;
    end
    else
    begin
      resv_r <= 1'b0;
      case (state_r)
        cpuie_pkg::S_IDLE:
        begin
          is_return_from_irq_instr_r <= return_from_irq_instr_in;
          if (go_ret_c)
            state_r <= cpuie_pkg::S_RPC;
          else if (go_trap_c)
          begin
            kind_r <= cpuie_pkg::K_TRAP;
            vec_r <= trap_vec_in;
            state_r <= cpuie_pkg::S_PSR;
          end
          else if (go_abt_c)
          begin
            kind_r <= cpuie_pkg::K_ABT;
            vec_r <= cpuie_pkg::VEC_ABT;
            state_r <= cpuie_pkg::S_PSR;
          end
          else if (go_irq_c)
          begin
            kind_r <= go_nmi_c ? cpuie_pkg::K_NMI : cpuie_pkg::K_INT;
            state_r <= cpuie_pkg::S_ACK;
          end
        end
        cpuie_pkg::S_ACK:
          if (done_c)
          begin
            state_r <= cpuie_pkg::S_PSR;
            if (kind_r == cpuie_pkg::K_NMI)
              vec_r <= cpuie_pkg::VEC_NMI;
            else if (!cfg_vec_r)
              vec_r <= cpuie_pkg::VEC_NOVEC;
            else if (!rbyte_c[7])
              vec_r <= rbyte_c;
            else if (rbyte_casc_c)
            begin
              byte_r <= rbyte_c;
              state_r <= cpuie_pkg::S_CADDR;
            end
            else
            begin
              vec_r <= cpuie_pkg::VEC_NOVEC;
              resv_r <= 1'b1;
            end
          end
        cpuie_pkg::S_CADDR:
          if (done_c)
            state_r <= cpuie_pkg::S_CACK;
        cpuie_pkg::S_CACK:
          if (done_c)
          begin
            vec_r <= rbyte_c;
            state_r <= cpuie_pkg::S_PSR;
          end
        cpuie_pkg::S_PSR:
          if (done_c)
            state_r <= cpuie_pkg::S_DESC;
        cpuie_pkg::S_DESC:
          if (done_c)
            state_r <= cpuie_pkg::S_SB;
        cpuie_pkg::S_SB:
          if (done_c)
            state_r <= cpuie_pkg::S_PB;
        cpuie_pkg::S_PB:
          if (done_c)
            state_r <= cpuie_pkg::S_MOD;
        cpuie_pkg::S_MOD:
          if (done_c)
            state_r <= cpuie_pkg::S_PC;
        cpuie_pkg::S_RPC:
          if (done_c)
            state_r <= cpuie_pkg::S_RMOD;
        cpuie_pkg::S_RMOD:
          if (done_c)
            state_r <= cpuie_pkg::S_RPSR;
        cpuie_pkg::S_RPSR:
          if (done_c)
            state_r <= cpuie_pkg::S_RSB;
        cpuie_pkg::S_RSB:
          if (done_c)
            state_r <= is_return_from_irq_instr_r ? cpuie_pkg::S_EOIM : cpuie_pkg::S_IDLE;
        cpuie_pkg::S_EOIM:
          if (done_c)
          begin
            byte_r <= rbyte_c;
            state_r <= (rbyte_c[7] && rbyte_casc_c) ?
              cpuie_pkg::S_EOICA : cpuie_pkg::S_IDLE;
          end
        cpuie_pkg::S_EOICA:
          if (done_c)
            state_r <= cpuie_pkg::S_EOIC;
        cpuie_pkg::S_PC, cpuie_pkg::S_EOIC:
          if (done_c)
            state_r <= cpuie_pkg::S_IDLE;
        default:
          state_r <= cpuie_pkg::S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // busy flag, set on leaving idle, cleared on the last answer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      busy_r <= 1'b0;
    else if (go_ret_c || go_trap_c || go_abt_c || go_irq_c)
      busy_r <= 1'b1;
    else if (idle_c || (done_c && (state_r == cpuie_pkg::S_PC ||
      state_r == cpuie_pkg::S_EOIC ||
      (state_r == cpuie_pkg::S_RSB && !is_return_from_irq_instr_r) ||
      (state_r == cpuie_pkg::S_EOIM && !rbyte_casc_c))))
      busy_r <= 1'b0;
  end

  // ---------------------------------------------------------------
  // processor registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      psr_r <= cpuie_pkg::PSR_RST;
      psr_copy_r <= 16'h0000;
      mod_r <= 16'h0000;
      offs_r <= 16'h0000;
      discard_r <= 16'h0000;
      sb_r <= 32'h00000000;
      pc_r <= 32'h00000000;
      isp_r <= 32'h00000000;
      base_r <= 32'h00000000;
      caddr_r <= 32'h00000000;
      ret_pc_r <= 32'h00000000;
      cfg_vec_r <= 1'b0;
    end
    else
    begin
      if (idle_c)
      begin
        if (set_config_instr_in)
          cfg_vec_r <= cfg_vectored_in;
        if (base_load_in)
          base_r <= base_wdata_in;
        if (isp_load_in)
          isp_r <= isp_wdata_in;
        if (go_ret_c)
          discard_r <= return_from_trap_instr_in ? return_from_trap_instr_discard_in : 16'h0000;
        else if (go_trap_c || go_abt_c || go_irq_c)
        begin
          ret_pc_r <= ret_addr_in;
          // trap keeps enable; abort drops trace pending before the copy
          psr_copy_r <= go_abt_c ? (psr_r & ~(16'h0001 << cpuie_pkg::PSR_P))
            : psr_r;
          psr_r <= psr_r & ~((16'h0001 << cpuie_pkg::PSR_S) |
            (16'h0001 << cpuie_pkg::PSR_U) | (16'h0001 << cpuie_pkg::PSR_T) |
            (16'h0001 << cpuie_pkg::PSR_P) |
            (go_trap_c ? 16'h0000 : (16'h0001 << cpuie_pkg::PSR_I)));
        end
        else if (psr_load_in)
          psr_r <= psr_wdata_in;
      end
      if (done_c)
        case (state_r)
          cpuie_pkg::S_CADDR, cpuie_pkg::S_EOICA:
            caddr_r <= bus_rdata_in;
          cpuie_pkg::S_PSR, cpuie_pkg::S_MOD:
            isp_r <= isp_r - cpuie_pkg::OFS_HALF;
          cpuie_pkg::S_DESC:
          begin
            mod_r <= bus_rdata_in[15:0];
            offs_r <= bus_rdata_in[31:16];
          end
          cpuie_pkg::S_SB, cpuie_pkg::S_RSB:
            sb_r <= bus_rdata_in;
          cpuie_pkg::S_PB:
            pc_r <= bus_rdata_in + {16'h0000, offs_r};
          cpuie_pkg::S_PC:
            isp_r <= isp_r - cpuie_pkg::OFS_WORD;
          cpuie_pkg::S_RPC:
            pc_r <= bus_rdata_in;
          cpuie_pkg::S_RMOD:
            mod_r <= bus_rdata_in[15:0];
          cpuie_pkg::S_RPSR:
          begin
            psr_r <= bus_rdata_in[15:0];
            isp_r <= isp_r + cpuie_pkg::OFS_FRAME +
              {16'h0000, discard_r};
          end
          default:
            caddr_r <= caddr_r;
        endcase
    end
  end

  // ---------------------------------------------------------------
  // instruction status pins, from execution events
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      start_pulse_n_r <= 1'b1;
      user_r <= 1'b0;
      lock_n_r <= 1'b1;
    end
    else
    begin
      start_pulse_n_r <= !instr_start_in;
      user_r <= psr_r[cpuie_pkg::PSR_U];
      lock_n_r <= !(set_bit_locked_instr_in ||
        clear_bit_locked_instr_in);
    end
  end

  assign bus_req_out = req_r;
  assign bus_cmd_out = cmd_r;
  assign instr_start_pulse_n_out = start_pulse_n_r;
  assign user_mode_out = user_r;
  assign interlock_n_out = lock_n_r;
  assign busy_out = busy_r;
  assign reserved_vec_out = resv_r;
  assign psr_out = psr_r;
  assign module_reg_out = mod_r;
  assign static_base_out = sb_r;
  assign pc_out = pc_r;
  assign isp_out = isp_r;
  assign vector_out = vec_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  property p_start_pulse;
    instr_start_in |=> !instr_start_pulse_n_out;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start pin not pulsed");
  property p_user_pin;
    ##1 user_mode_out == $past(psr_out[cpuie_pkg::PSR_U]);
  endproperty
  a_user_pin: assert property (p_user_pin)
    else $error("user pin does not follow status word");
  property p_lock;
    (set_bit_locked_instr_in || clear_bit_locked_instr_in)
      |=> !interlock_n_out;
  endproperty
  a_lock: assert property (p_lock)
    else $error("interlock pin not active");
  property p_int_mask;
    go_int_c |-> psr_out[cpuie_pkg::PSR_I] ##1
      !psr_out[cpuie_pkg::PSR_I] && !psr_out[cpuie_pkg::PSR_S];
  endproperty
  a_int_mask: assert property (p_int_mask)
    else $error("maskable entry with enable clear");
  property p_psr_push;
    bus_req_out && bus_cmd_out.write && bus_cmd_out.size ==
      cpuie_pkg::SZ_HALF && state_r == cpuie_pkg::S_PSR |->
      bus_cmd_out.addr == isp_out - cpuie_pkg::OFS_HALF;
  endproperty
  a_psr_push: assert property (p_psr_push)
    else $error("status push address wrong");
  property p_novec;
    state_r == cpuie_pkg::S_ACK && done_c && !cfg_vec_r &&
      kind_r == cpuie_pkg::K_INT |=> vector_out == cpuie_pkg::VEC_NOVEC
      && state_r == cpuie_pkg::S_PSR;
  endproperty
  a_novec: assert property (p_novec)
    else $error("nonvectored vector not zero");
  property p_ack_addr;
    bus_req_out && bus_cmd_out.status == cpuie_pkg::STS_ACK_MASTER |->
      bus_cmd_out.addr == (cfg_vec_r && kind_r == cpuie_pkg::K_INT ?
      cpuie_pkg::ADDR_ACK_VEC : cpuie_pkg::ADDR_ACK_NOVEC);
  endproperty
  a_ack_addr: assert property (p_ack_addr)
    else $error("acknowledge address wrong");
  property p_casc_addr;
    bus_req_out && state_r == cpuie_pkg::S_CADDR |->
      bus_cmd_out.addr == base_r + {{22{byte_r[7]}}, byte_r, 2'b00};
  endproperty
  a_casc_addr: assert property (p_casc_addr)
    else $error("cascade table address wrong");
  property p_casc_ack;
    state_r == cpuie_pkg::S_CADDR && done_c |=> ##[1:2] bus_req_out &&
      bus_cmd_out.status == cpuie_pkg::STS_ACK_CASC &&
      bus_cmd_out.addr == caddr_r;
  endproperty
  a_casc_ack: assert property (p_casc_ack)
    else $error("cascaded acknowledge missing");
  c_vectored: cover property (state_r == cpuie_pkg::S_ACK && done_c &&
    cfg_vec_r && !rbyte_c[7]);
  c_cascaded: cover property (state_r == cpuie_pkg::S_CACK && done_c);
  c_eoi_casc: cover property (state_r == cpuie_pkg::S_EOIC && done_c);
  c_abort: cover property (go_abt_c);

endmodule : cpuie_top

/* File: design/cpuie_pkg.sv */
// Purpose: shared constants and types of the interrupt entry block
// Assumes: 32-bit addresses, 16-bit status word
// Notes: status word bit positions and end-of-interrupt codes are fixed here
package cpuie_pkg;

  // ---------------------------------------------------------------
  // status word fields
  // ---------------------------------------------------------------
  localparam int PSR_T = 1;
  localparam int PSR_U = 8;
  localparam int PSR_S = 9;
  localparam int PSR_P = 10;
  localparam int PSR_I = 11;
  localparam logic [15:0] PSR_RST = 16'h0000;

  // ---------------------------------------------------------------
  // bus cycle status codes and fixed addresses
  // ---------------------------------------------------------------
  localparam logic [3:0] STS_ACK_MASTER = 4'h4;
  localparam logic [3:0] STS_ACK_CASC = 4'h5;
  localparam logic [3:0] STS_EOI_MASTER = 4'h6;
  localparam logic [3:0] STS_EOI_CASC = 4'h7;
  localparam logic [3:0] STS_DATA = 4'ha;
  localparam logic [31:0] ADDR_ACK_VEC = 32'h00fffe00;
  localparam logic [31:0] ADDR_ACK_NOVEC = 32'h00ffff00;

  // ---------------------------------------------------------------
  // access sizes, vectors, stack frame offsets
  // ---------------------------------------------------------------
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h3;
  localparam logic [7:0] VEC_NOVEC = 8'h00;
  localparam logic [7:0] VEC_NMI = 8'h01;
  localparam logic [7:0] VEC_ABT = 8'h02;
  localparam logic [7:0] CASC_MIN = 8'hf0;
  localparam logic [31:0] OFS_HALF = 32'h00000002;
  localparam logic [31:0] OFS_WORD = 32'h00000004;
  localparam logic [31:0] OFS_POP_PSR = 32'h00000006;
  localparam logic [31:0] OFS_FRAME = 32'h00000008;
  localparam logic [31:0] OFS_PROG_BASE = 32'h00000008;

  typedef enum logic [1:0] {
    K_TRAP,
    K_ABT,
    K_NMI,
    K_INT
  } cpuie_kind_t;

  typedef enum logic [4:0] {
    S_IDLE, S_ACK, S_CADDR, S_CACK, S_PSR, S_DESC, S_SB, S_PB, S_MOD,
    S_PC, S_RPC, S_RMOD, S_RPSR, S_RSB, S_EOIM, S_EOICA, S_EOIC
  } cpuie_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0] size;
    logic write;
    logic [3:0] status;
  } cpuie_bus_cmd_t;

endpackage : cpuie_pkg

/* File: tb/cpuie_bus_model.sv */
// Purpose: far-side memory and interrupt control units
// Assumes: one request at a time, answered after three cycles
// Notes: read data is inverted every cycle outside the answer
`timescale 1ns/1ps
module cpuie_bus_model (
  input wire logic clk_in,
  input wire logic req_in,
  input cpuie_pkg::cpuie_bus_cmd_t cmd_in,
  input wire logic [7:0] ack_in,
  output logic done_out,
  output logic [31:0] rdata_out
);
  logic [1:0] cnt_r = 2'h0;
  logic [31:0] mem [logic [31:0]];
  initial done_out = 1'b0;
  initial rdata_out = 32'h5a5a5a5a;
  always @(posedge clk_in)
  begin
    done_out <= 1'b0;
    rdata_out <= ~rdata_out;
    if (req_in && !done_out)
      cnt_r <= cnt_r + 2'h1;
    if (req_in && !done_out && cnt_r == 2'h2)
    begin
      done_out <= 1'b1;
      cnt_r <= 2'h0;
      if (cmd_in.write)
        mem[cmd_in.addr] = cmd_in.wdata;
      if (cmd_in.status[2])
        rdata_out <= {24'h0, ack_in};
      else if (mem.exists(cmd_in.addr))
        rdata_out <= mem[cmd_in.addr];
      else
        rdata_out <= cmd_in.addr + 32'h10;
    end
  end
endmodule : cpuie_bus_model

/* File: tb/cpuie_top_tb.sv */
// Purpose: self-checking bench of the interrupt entry block
// Assumes: bus model answers every request
// Notes: entries are logged as the bus commands complete
`timescale 1ns/1ps
module cpuie_top_tb;
  logic clk_in, nrst_in, st, bnd, sl, int_n, abt_n, return_from_irq_instr, cg, cfg;
  logic pl, ld, done, req, busy, stp_n, um, ilk_n;
  logic clr, nmi_n, trap, return_from_trap_instr;
  logic [7:0] ack, vec;
  logic [15:0] processor_status_word, pw;
  logic [31:0] rd, pc, isp;
  cpuie_pkg::cpuie_bus_cmd_t cmd;
  cpuie_pkg::cpuie_bus_cmd_t lq [$];
  int miscompares = 0;
  int checks_done = 0;
  cpuie_top dut (.clk_in(clk_in), .nrst_in(nrst_in), .instr_start_in(st),
    .instr_boundary_in(bnd), .ret_addr_in(32'h0000abcd),
    .set_bit_locked_instr_in(sl), .clear_bit_locked_instr_in(clr),
    .int_n_in(int_n), .nmi_n_in(nmi_n), .reset_abort_n_in(abt_n),
    .trap_req_in(trap), .trap_vec_in(8'h04),
    .return_from_trap_instr_in(return_from_trap_instr), .return_from_trap_instr_discard_in(16'h0004),
    .return_from_irq_instr_in(return_from_irq_instr), .set_config_instr_in(cg),
    .cfg_vectored_in(cfg), .psr_load_in(pl), .psr_wdata_in(pw),
    .base_load_in(ld), .base_wdata_in(32'h00001000), .isp_load_in(ld),
    .isp_wdata_in(32'h00002000), .bus_done_in(done), .bus_rdata_in(rd),
    .bus_req_out(req), .bus_cmd_out(cmd), .instr_start_pulse_n_out(stp_n),
    .user_mode_out(um), .interlock_n_out(ilk_n), .busy_out(busy),
    .reserved_vec_out(), .psr_out(processor_status_word), .module_reg_out(),
    .static_base_out(), .pc_out(pc), .isp_out(isp), .vector_out(vec));
  cpuie_bus_model far (.clk_in(clk_in), .req_in(req), .cmd_in(cmd),
    .ack_in(ack), .done_out(done), .rdata_out(rd));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(string n, logic [31:0] s, logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  task automatic idle();
    int k;
    k = 0;
    repeat (3) @(posedge clk_in);
    #1;
    while (busy !== 1'b0 && k < 300)
    begin
      @(posedge clk_in);
      #1;
      k++;
    end
    check("busy", busy, 0);
  endtask : idle
  task automatic irq(logic c, logic [7:0] b);
    lq.delete();
    @(posedge clk_in);
    cfg <= c;
    cg <= 1'b1;
    ack <= b;
    @(posedge clk_in);
    cg <= 1'b0;
    int_n <= 1'b0;
    bnd <= 1'b1;
    @(posedge clk_in);
    int_n <= 1'b1;
    bnd <= 1'b0;
    idle();
  endtask : irq
  task automatic ret_irq();
    @(posedge clk_in);
    return_from_irq_instr <= 1'b1;
    @(posedge clk_in);
    return_from_irq_instr <= 1'b0;
    idle();
  endtask : ret_irq
  // ---------------------------------------------------------------
  // stimulus
  // ---------------------------------------------------------------
  always @(posedge clk_in)
    if (req && done)
      lq.push_back(cmd);
  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  initial
  begin
    #40000;
    miscompares++;
    wrap_up();
  end
  initial
  begin
    {nrst_in, st, bnd, sl, return_from_irq_instr, cg, cfg, pl, ld, ack, pw} = '0;
    {clr, trap, return_from_trap_instr} = 3'h0;
    {int_n, abt_n, nmi_n} = 3'h7;
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    pw <= 16'h0900;
    pl <= 1'b1;
    ld <= 1'b1;
    st <= 1'b1;
    sl <= 1'b1;
    @(posedge clk_in);
    {pl, ld, st, sl, clr} <= 5'h01;
    #1;
    check("start", stp_n, 0);
    check("lock", ilk_n, 0);
    @(posedge clk_in);
    clr <= 1'b0;
    #1;
    check("start end", stp_n, 1);
    check("user", um, 1);
    check("lock clr", ilk_n, 0);
    irq(1'b1, 8'h05);
    check("ack addr", lq[0].addr, 32'h00fffe00);
    check("ack code", lq[0].status, 4'h4);
    check("psr push", lq[1].wdata[15:0], 16'h0900);
    check("push size", lq[1].size, 2'h1);
    check("desc", lq[2].addr, 32'h00001014);
    check("n cmds", lq.size(), 7);
    check("vec", vec, 8'h05);
    check("ie off", processor_status_word[11], 0);
    check("user off", um, 0);
    ret_irq();
    check("eoi", lq[lq.size()-1].status, 4'h6);
    check("psr back", processor_status_word, 16'h0900);
    irq(1'b0, 8'h05);
    check("nv addr", lq[0].addr, 32'h00ffff00);
    check("nv vec", vec, 8'h00);
    ret_irq();
    irq(1'b1, 8'hf0);
    check("casc tbl", lq[1].addr, 32'h00000fc0);
    check("casc ack", lq[2].addr, 32'h00000fd0);
    check("casc code", lq[2].status, 4'h5);
    check("casc vec", vec, 8'hf0);
    ret_irq();
    check("ceoi", lq[lq.size()-1].status, 4'h7);
    @(posedge clk_in);
    pw <= 16'h0000;
    pl <= 1'b1;
    @(posedge clk_in);
    pl <= 1'b0;
    int_n <= 1'b0;
    bnd <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    check("masked", busy, 0);
    lq.delete();
    @(posedge clk_in);
    {int_n, bnd, abt_n} <= 3'h4;
    @(posedge clk_in);
    abt_n <= 1'b1;
    idle();
    check("abort vec", vec, 8'h02);
    lq.delete();
    @(posedge clk_in);
    {nmi_n, bnd} <= 2'h1;
    repeat (2) @(posedge clk_in);
    {nmi_n, bnd} <= 2'h2;
    idle();
    check("nmi desc", lq[2].addr, 32'h00001004);
    @(posedge clk_in);
    return_from_trap_instr <= 1'b1;
    @(posedge clk_in);
    return_from_trap_instr <= 1'b0;
    idle();
    check("return_from_trap_instr cmds", lq.size(), 11);
    check("return_from_trap_instr pc", pc, 32'h0000abcd);
    check("return_from_trap_instr isp", isp, 32'h00001ffc);
    lq.delete();
    @(posedge clk_in);
    {trap, bnd} <= 2'h3;
    @(posedge clk_in);
    {trap, bnd} <= 2'h0;
    idle();
    check("trap desc", lq[1].addr, 32'h00001010);
    check("trap vec", vec, 8'h04);
    wrap_up();
  end
endmodule : cpuie_top_tb
